// ---- src/pvsf_framer.sv ----
// Pixel capture, link framing, control-channel routing and reverse gating.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RL1: Single input latches one word per cycle.
// RL2: Double input latches halves on consecutive cycles.
// RL3: Double input halves join into one word.
// RL4: Scramble first, then 8b/10b encode.
// RL5: Video field is 22 or 30 bits.
// RL6: Control bit sits right after video bits.
// RL7: Last bit is parity of preceding bits.
// RL8: Parity is even.
// RL9: Input bits mapped by coding, width, mode.
// RL10: Reverse channel unused until 2 ms.
// RL11: Link start or stop mutes reverse 350 us.
// RL12: Low rate needs slow pixel clock range.
// RL13: Avoid double input with low rate.
// RL14: Double input clock 33.3-100 or 25-75 MHz.
// RL15: Single input clock 6.25 to 50 MHz.
// RL16: Mode pin selects base or bypass channel.
// RL17: Base mode reaches both link ends.
// RL18: Own address programmable, defaults 0x80, 0x90.
// RL19: Foreign packets become I2C at same rate.
// RL20: Read-only flag shows valid pixel clock.
// RL21: Sync encoding resets off.
// RL22: Error coding resets to parity only.

module pvsf_framer #(
    parameter int         PWRUP_CYC   = pvsf_pkg::PWRUP_CYC,
    parameter int         REVHOLD_CYC = pvsf_pkg::REVHOLD_CYC,
    parameter logic [7:0] PART_ID     = 8'h5a,  // Arbitrary value.
    parameter logic [3:0] REVISION    = 4'h1    // Arbitrary value.
) (
    // Clock and reset.
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Parallel pixel input, on the pixel clock.
    input  wire pvsf_pkg::pvsf_pix_t   pixel,
    // Slow pins, synchronised inside.
    input  wire logic                  fcc_in,
    input  wire logic                  control_mode_select,
    input  wire logic                  cable_type_pin,
    input  wire logic                  host_iface_pin,
    input  wire logic                  rev_ctrl_in,
    // Control-channel packets and their routing.
    input  wire pvsf_pkg::pvsf_cmd_t   cmd,
    output pvsf_pkg::pvsf_route_t      route,
    // Encoded link output.
    output pvsf_pkg::pvsf_tx_t         tx,
    // Reverse channel and status.
    output logic                       rev_ctrl_out,
    output logic                       rev_chan_ready,
    output logic                       bypass_active,
    output logic                       local_ctrl_chan_enable,
    output logic                       serial_output_enable,
    output logic                       pixel_clock_detected
);
    import pvsf_pkg::*;

    localparam logic [PU_W-1:0]   PU_LAST   = PU_W'(PWRUP_CYC - 1);
    localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(REVHOLD_CYC);

    pvsf_state_t       state_r;
    pvsf_state_t       state_nxt;
    logic [31:0]       link_word;
    logic              fcc_bit;
    logic [SYNC_W-1:0] pins_in;

    // 8b/10b of one byte; returns {new disparity, abcdei, fghj}.
    function automatic logic [10:0] enc8b10b(input logic [7:0] d,
                                             input logic       rd);
        logic [5:0] c6;
        logic [3:0] c4;
        logic       r;
        logic       alt;
        r = rd;
        unique case (d[4:0])
            5'h00: c6 = 6'h27;  5'h01: c6 = 6'h1d;  5'h02: c6 = 6'h2d;
            5'h03: c6 = 6'h31;  5'h04: c6 = 6'h35;  5'h05: c6 = 6'h29;
            5'h06: c6 = 6'h19;  5'h07: c6 = 6'h38;  5'h08: c6 = 6'h39;
            5'h09: c6 = 6'h25;  5'h0a: c6 = 6'h15;  5'h0b: c6 = 6'h34;
            5'h0c: c6 = 6'h0d;  5'h0d: c6 = 6'h2c;  5'h0e: c6 = 6'h1c;
            5'h0f: c6 = 6'h17;  5'h10: c6 = 6'h1b;  5'h11: c6 = 6'h23;
            5'h12: c6 = 6'h13;  5'h13: c6 = 6'h32;  5'h14: c6 = 6'h0b;
            5'h15: c6 = 6'h2a;  5'h16: c6 = 6'h1a;  5'h17: c6 = 6'h3a;
            5'h18: c6 = 6'h33;  5'h19: c6 = 6'h26;  5'h1a: c6 = 6'h16;
            5'h1b: c6 = 6'h36;  5'h1c: c6 = 6'h0e;  5'h1d: c6 = 6'h2e;
            5'h1e: c6 = 6'h1e;  5'h1f: c6 = 6'h2b;
        endcase
        // Unbalanced codes and the D.7 pair follow the running disparity.
        if (r && (($countones(c6) != 3) || (d[4:0] == 5'h07))) begin
            c6 = ~c6;
        end
        if ($countones(c6) != 3) begin
            r = ~r;
        end
        // The alternate D.x.7 keeps the run length within five.
        alt = (!r && (d[4:0] == 5'h11 || d[4:0] == 5'h12 ||
                      d[4:0] == 5'h14)) ||
              (r && (d[4:0] == 5'h0b || d[4:0] == 5'h0d ||
                     d[4:0] == 5'h0e));
        unique case (d[7:5])
            3'h0: c4 = 4'hb;  3'h1: c4 = 4'h9;  3'h2: c4 = 4'h5;
            3'h3: c4 = 4'hc;  3'h4: c4 = 4'hd;  3'h5: c4 = 4'ha;
            3'h6: c4 = 4'h6;  3'h7: c4 = alt ? 4'h7 : 4'he;
        endcase
        if (r && (($countones(c4) != 2) || (d[7:5] == 3'h3))) begin
            c4 = ~c4;
        end
        if ($countones(c4) != 2) begin
            r = ~r;
        end
        return {r, c6, c4};
    endfunction

    // The control bit idles high while the local channel is off.
    assign pins_in = {fcc_in, rev_ctrl_in, host_iface_pin,
                      cable_type_pin, control_mode_select};
    assign fcc_bit = state_r.lcc_en ? state_r.sync2[SY_FCC] : 1'b1;

    pvsf_word_map u_word_map (
        .cfg       (state_r.cfg),
        .half_a    (state_r.lat_a),
        .half_b    (state_r.lat_b),
        .fcc_bit   (fcc_bit),
        .link_word (link_word)
    );

    // Next state: synchronisers, capture, registers, timers and framing.
    always_comb begin
        logic [7:0]  rdata;
        logic [31:0] scr;
        logic [10:0] enc;
        logic        rd_v;
        logic        ready_v;
        rdata     = 8'h00;
        scr       = 32'h0000_0000;
        enc       = 11'h000;
        rd_v      = state_r.rd;
        ready_v   = 1'b0;
        state_nxt = state_r;
        state_nxt.sync1 = pins_in;
        state_nxt.sync2 = state_r.sync1;

        // Input capture; a half left over when the mode drops is discarded.
        state_nxt.cap_vld = 1'b0;
        if (!state_r.cfg.double_input_select) begin
            state_nxt.phase = PH_FIRST;
            if (pixel.valid) begin
                state_nxt.lat_a   = pixel;  // see RL1
                state_nxt.cap_vld = 1'b1;
            end
        end else if (pixel.valid) begin
            unique case (state_r.phase)
                PH_FIRST: begin
                    state_nxt.lat_a = pixel;  // see RL2
                    state_nxt.phase = PH_SECOND;
                end
                PH_SECOND: begin
                    state_nxt.lat_b   = pixel;  // see RL2
                    state_nxt.phase   = PH_FIRST;
                    state_nxt.cap_vld = 1'b1;  // see RL3
                end
            endcase
        end

        // Pixel activity detector with a short window either way.
        if (pixel.valid) begin
            state_nxt.gap_cnt = 4'h0;
            if (state_r.det_cnt == DET_CYC - 4'h1) begin
                state_nxt.pclk_det = 1'b1;  // see RL20
            end else begin
                state_nxt.det_cnt = state_r.det_cnt + 4'h1;
            end
        end else begin
            state_nxt.det_cnt = 4'h0;
            if (state_r.gap_cnt == DET_CYC - 4'h1) begin
                state_nxt.pclk_det = 1'b0;  // see RL20
            end else begin
                state_nxt.gap_cnt = state_r.gap_cnt + 4'h1;
            end
        end

        // Power-up wait and the mute window after link start or stop.
        if (!state_r.pu_done) begin
            if (state_r.pu_cnt == PU_LAST) begin
                state_nxt.pu_done = 1'b1;  // see RL10
            end else begin
                state_nxt.pu_cnt = state_r.pu_cnt + 1'b1;
            end
        end
        if (state_r.hold_cnt != '0) begin
            state_nxt.hold_cnt = state_r.hold_cnt - 1'b1;
        end

        // Register read view, zero for reserved and unmapped offsets.
        unique case (cmd.reg_addr)
            REG_OWN_ADDR:    rdata = state_r.own_addr;
            REG_REMOTE_ADDR: rdata = state_r.remote_addr;
            REG_LINK_CFG:    rdata = state_r.cfg;
            REG_LINK_STAT: begin
                rdata[STAT_CABLE]   = state_r.sync2[SY_CABLE];
                rdata[STAT_HOSTIF]  = state_r.sync2[SY_HOSTIF];
                rdata[STAT_LCC]     = state_r.lcc_en;
                rdata[STAT_OUTEN]   = state_r.out_en;
                rdata[STAT_PIXEL_CLOCK_DETECTED] = state_r.pclk_det;  // see RL20
            end
            REG_PART_ID:     rdata = PART_ID;
            REG_CAP_REV:     rdata = {4'h0, REVISION};
            default:         rdata = 8'h00;
        endcase

        // Packets are served only in base mode; bypass leaves them alone.
        state_nxt.route.rsp_valid  = 1'b0;
        state_nxt.route.remote_fwd = 1'b0;
        state_nxt.route.i2c_req    = 1'b0;
        if (cmd.valid && !state_r.sync2[SY_MODE]) begin  // see RL16
            if (cmd.dev_addr == state_r.own_addr) begin  // see RL17
                state_nxt.route.rsp_valid = 1'b1;
                state_nxt.route.rsp_rdata = rdata;
                if (cmd.write) begin
                    unique case (cmd.reg_addr)
                        REG_OWN_ADDR:    state_nxt.own_addr = cmd.wdata;
                        REG_REMOTE_ADDR: state_nxt.remote_addr = cmd.wdata;
                        REG_LINK_CFG:    state_nxt.cfg = cmd.wdata;
                        REG_LINK_STAT: begin
                            state_nxt.lcc_en = cmd.wdata[STAT_LCC];
                            state_nxt.out_en = cmd.wdata[STAT_OUTEN];
                        end
                        default: state_nxt.cfg = state_r.cfg;
                    endcase
                end
            end else if (cmd.dev_addr == state_r.remote_addr) begin
                state_nxt.route.remote_fwd = 1'b1;  // see RL17
            end else begin
                state_nxt.route.i2c_req    = 1'b1;  // see RL19
                state_nxt.route.bit_period = cmd.bit_period;  // see RL19
            end
        end
        if (state_nxt.out_en != state_r.out_en) begin
            state_nxt.hold_cnt = HOLD_LOAD;  // see RL11
        end

        // Reverse data idles high while the receiver is muted.
        ready_v = state_r.pu_done && (state_r.hold_cnt == '0);
        state_nxt.rev_out = ready_v ? state_r.sync2[SY_REV] : 1'b1;

        // Scramble the whole word, then encode 3 or 4 bytes in order.
        state_nxt.tx.valid = 1'b0;
        if (!state_r.out_en) begin
            state_nxt.lfsr = LFSR_SEED;
            state_nxt.rd   = 1'b0;
        end else if (state_r.cap_vld) begin
            scr = link_word ^ state_r.lfsr;  // see RL4
            state_nxt.lfsr = {state_r.lfsr[30:0], 1'b0} ^
                             (state_r.lfsr[31] ? LFSR_POLY : 32'h0000_0000);
            for (int i = 0; i < 4; i++) begin
                if (i < 3 || state_r.cfg.bus_width_select) begin
                    enc  = enc8b10b(scr[8*i +: 8], rd_v);  // see RL4
                    rd_v = enc[10];
                    state_nxt.tx.symbols[10*i +: 10] = enc[9:0];
                end else begin
                    state_nxt.tx.symbols[10*i +: 10] = 10'h000;
                end
            end
            state_nxt.rd       = rd_v;
            state_nxt.tx.count = state_r.cfg.bus_width_select ? 3'h4 : 3'h3;
            state_nxt.tx.valid = 1'b1;
        end
    end

    // State register; reset values put the link quiet and the channel idle.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r             <= '0;
            state_r.phase       <= PH_FIRST;
            state_r.own_addr    <= RST_OWN_ADDR;  // see RL18
            state_r.remote_addr <= RST_REMOTE_ADDR;  // see RL18
            state_r.cfg         <= RST_LINK_CFG;  // see RL21, RL22
            state_r.lfsr        <= LFSR_SEED;
            state_r.rev_out     <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign route                  = state_r.route;
    assign tx                     = state_r.tx;
    assign rev_ctrl_out           = state_r.rev_out;
    assign rev_chan_ready = state_r.pu_done && (state_r.hold_cnt == '0);
    assign bypass_active          = state_r.sync2[SY_MODE];
    assign local_ctrl_chan_enable = state_r.lcc_en;
    assign serial_output_enable   = state_r.out_en;
    assign pixel_clock_detected   = state_r.pclk_det;

    chk_single_capture: assert property (@(posedge clk) disable iff (rst) // see RL1
        !state_r.cfg.double_input_select && pixel.valid |=>
            state_r.cap_vld && state_r.lat_a.data == $past(pixel.data))
        else $error("single input word not latched");

    chk_double_first: assert property (@(posedge clk) disable iff (rst) // see RL2
        state_r.cfg.double_input_select && !cmd.valid && pixel.valid &&
            state_r.phase == PH_FIRST |=>
            state_r.phase == PH_SECOND && !state_r.cap_vld)
        else $error("first half not held for its partner");

    chk_double_joined: assert property (@(posedge clk) disable iff (rst) // see RL3
        state_r.cfg.double_input_select && !cmd.valid && pixel.valid &&
            state_r.phase == PH_SECOND |=>
            state_r.cap_vld && state_r.lat_b.data == $past(pixel.data))
        else $error("second half not joined");

    chk_encode_follows: assert property (@(posedge clk) disable iff (rst) // see RL4
        state_r.cap_vld && state_r.out_en |=>
            tx.valid && tx.count == ($past(state_r.cfg.bus_width_select) ? 3'h4 : 3'h3))
        else $error("captured word not encoded next cycle");

    chk_word_parity: assert property (@(posedge clk) disable iff (rst) // see RL7
        (^link_word) == 1'b0)
        else $error("link word parity is not even");

    chk_fcc_position: assert property (@(posedge clk) disable iff (rst) // see RL6
        (state_r.cfg.bus_width_select ? link_word[30] : link_word[22]) == fcc_bit)
        else $error("control bit misplaced");

    chk_powerup_wait: assert property (@(posedge clk) disable iff (rst) // see RL10
        rev_chan_ready |-> state_r.pu_cnt == PU_LAST)
        else $error("reverse channel ready before power-up wait");

    chk_reverse_mute: assert property (@(posedge clk) disable iff (rst) // see RL11
        $changed(state_r.out_en) |-> !rev_chan_ready ##1 !rev_chan_ready)
        else $error("reverse channel not muted on link change");

    chk_bypass_ignore: assert property (@(posedge clk) disable iff (rst) // see RL16
        cmd.valid && bypass_active |=>
            !route.rsp_valid && !route.remote_fwd && !route.i2c_req)
        else $error("packet served in bypass mode");

    chk_i2c_rate: assert property (@(posedge clk) disable iff (rst) // see RL19
        route.i2c_req |-> route.bit_period == $past(cmd.bit_period))
        else $error("converted packet rate differs");

endmodule

`default_nettype wire

// ---- src/pvsf_pkg.sv ----
// Constants, carriers and state types of the pixel-to-link framer.
package pvsf_pkg;

    // Register offsets on the control-channel register port.
    localparam logic [7:0] REG_OWN_ADDR    = 8'h00;
    localparam logic [7:0] REG_REMOTE_ADDR = 8'h01;
    localparam logic [7:0] REG_LINK_CFG    = 8'h07;
    localparam logic [7:0] REG_LINK_STAT   = 8'h15;
    localparam logic [7:0] REG_RSVD_A      = 8'h16;
    localparam logic [7:0] REG_RSVD_B      = 8'h17;
    localparam logic [7:0] REG_PART_ID     = 8'h1e;
    localparam logic [7:0] REG_CAP_REV     = 8'h1f;

    // Reset values and the scrambler polynomial.
    localparam logic [7:0]  RST_OWN_ADDR    = 8'h80;
    localparam logic [7:0]  RST_REMOTE_ADDR = 8'h90;
    localparam logic [7:0]  RST_LINK_CFG    = 8'h00;
    localparam logic [31:0] LFSR_SEED       = 32'hffff_ffff;
    localparam logic [31:0] LFSR_POLY       = 32'h8020_0003;

    // Field positions in link_config_status.
    localparam int STAT_CABLE   = 7;
    localparam int STAT_HOSTIF  = 6;
    localparam int STAT_LCC     = 5;
    localparam int STAT_OUTEN   = 1;
    localparam int STAT_PIXEL_CLOCK_DETECTED = 0;

    // Synchroniser lanes for the slow pins.
    localparam int SY_MODE   = 0;
    localparam int SY_CABLE  = 1;
    localparam int SY_HOSTIF = 2;
    localparam int SY_REV    = 3;
    localparam int SY_FCC    = 4;
    localparam int SYNC_W    = 5;

    // Timing: times in their own unit, counts derived at the 40 MHz clock.
    localparam int CLK_MHZ     = 40;
    localparam int PWRUP_US    = 2000;
    localparam int REVHOLD_US  = 350;
    localparam int PWRUP_CYC   = PWRUP_US * CLK_MHZ;
    localparam int REVHOLD_CYC = REVHOLD_US * CLK_MHZ;
    localparam int PU_W        = 17;
    localparam int HOLD_W      = 14;
    localparam logic [3:0] DET_CYC = 4'h8;

    // Link configuration, laid out as register 0x07 (msb first).
    typedef struct packed {
        logic       double_input_select;
        logic       low_rate_select;
        logic       bus_width_select;
        logic       es;
        logic       rsvd;
        logic       sync_encode_enable;
        logic [1:0] edc;
    } pvsf_cfg_t;

    // One parallel input sample.
    typedef struct packed {
        logic        valid;
        logic        hs;
        logic        vs;
        logic [21:0] data;
    } pvsf_pix_t;

    // Decoded control-channel packet offered to the block.
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  dev_addr;
        logic [7:0]  reg_addr;
        logic [7:0]  wdata;
        logic [15:0] bit_period;
    } pvsf_cmd_t;

    // Answer and routing of a control-channel packet.
    typedef struct packed {
        logic        rsp_valid;
        logic [7:0]  rsp_rdata;
        logic        remote_fwd;
        logic        i2c_req;
        logic [15:0] bit_period;
    } pvsf_route_t;

    // Encoded link symbols, first symbol in bits 9:0.
    typedef struct packed {
        logic        valid;
        logic [2:0]  count;
        logic [39:0] symbols;
    } pvsf_tx_t;

    typedef enum logic [1:0] {
        PH_FIRST  = 2'b01,
        PH_SECOND = 2'b10
    } pvsf_phase_t;

    // Whole state of the framer.
    typedef struct packed {
        logic [SYNC_W-1:0] sync1;
        logic [SYNC_W-1:0] sync2;
        pvsf_phase_t       phase;
        pvsf_pix_t         lat_a;
        pvsf_pix_t         lat_b;
        logic              cap_vld;
        pvsf_cfg_t         cfg;
        logic [7:0]        own_addr;
        logic [7:0]        remote_addr;
        logic              lcc_en;
        logic              out_en;
        logic [PU_W-1:0]   pu_cnt;
        logic              pu_done;
        logic [HOLD_W-1:0] hold_cnt;
        logic [3:0]        det_cnt;
        logic [3:0]        gap_cnt;
        logic              pclk_det;
        logic [31:0]       lfsr;
        logic              rd;
        pvsf_tx_t          tx;
        pvsf_route_t       route;
        logic              rev_out;
    } pvsf_state_t;

endpackage

// ---- src/pvsf_word_map.sv ----
// Maps captured input words onto one link word with control and parity.
`timescale 1ns/1ps
`default_nettype none

module pvsf_word_map (
    // Configuration and captured halves.
    input  wire pvsf_pkg::pvsf_cfg_t cfg,
    input  wire pvsf_pkg::pvsf_pix_t half_a,
    input  wire pvsf_pkg::pvsf_pix_t half_b,
    input  wire logic                fcc_bit,
    // Assembled link word, upper byte zero in the narrow width.
    output logic [31:0]              link_word
);
    import pvsf_pkg::*;

    logic [29:0] vid;
    logic [29:0] data_part;
    logic [7:0]  chk;

    // Place the enabled input bits, then add check bits behind them.
    always_comb begin
        data_part = 30'h0000_0000;
        unique case ({|cfg.edc, cfg.bus_width_select, cfg.double_input_select})  // see RL22
            3'h0, 3'h2: begin
                data_part[21:0] = half_a.data;  // see RL9
                if (cfg.sync_encode_enable) begin
                    data_part[19:18] = {half_a.vs, half_a.hs};  // see RL21
                end
            end
            3'h1: data_part[21:0] = {half_b.data[10:0], half_a.data[10:0]};
            3'h3: data_part[29:0] = {half_b.data[14:0], half_a.data[14:0]};
            3'h4: data_part[15:0] = half_a.data[15:0];
            3'h5: data_part[15:0] = {half_b.data[7:0], half_a.data[7:0]};
            3'h6: begin
                data_part[21:0] = half_a.data;
                if (cfg.sync_encode_enable) begin
                    data_part[19:18] = {half_a.vs, half_a.hs};
                end
            end
            3'h7: data_part[23:0] = {half_b.data[11:0], half_a.data[11:0]};
        endcase
        // Positional check bits: bit k covers data whose index+1 has bit k.
        chk = 8'h00;
        for (int i = 0; i < 30; i++) begin
            for (int k = 0; k < 5; k++) begin
                if (((i + 1) >> k) % 2 == 1) begin
                    chk[k] = chk[k] ^ data_part[i];
                end
            end
        end
        chk[5] = ^data_part;
        vid = data_part;
        unique case ({|cfg.edc, cfg.bus_width_select, cfg.double_input_select})
            3'h4, 3'h5: vid[21:16] = chk[5:0];
            3'h6:       vid[29:22] = chk;
            3'h7:       vid[29:24] = chk[5:0];
            default:    vid = data_part;
        endcase
        // Even parity over everything that precedes the last bit.
        link_word = 32'h0000_0000;
        if (cfg.bus_width_select) begin
            link_word[29:0] = vid;  // see RL5
            link_word[30]   = fcc_bit;  // see RL6
            link_word[31]   = ^link_word[30:0];  // see RL7, RL8
        end else begin
            link_word[21:0] = vid[21:0];  // see RL5
            link_word[22]   = fcc_bit;  // see RL6
            link_word[23]   = ^link_word[22:0];  // see RL7, RL8
        end
    end

endmodule

`default_nettype wire

// ---- verif/pvsf_far_end.sv ----
// Far-end link model: counts words, holds reverse line low.
`timescale 1ns/1ps
`default_nettype none
module pvsf_far_end (
    // Link side.
    input  wire logic               clk,
    input  wire pvsf_pkg::pvsf_tx_t tx,
    output logic                    rev_line,
    output int                      n_words
);
    import pvsf_pkg::*;
    // A steady low shows whether the reverse gate lets it through.
    assign rev_line = 1'b0;
    int cnt = 0;
    // Each valid pulse is one whole link word; tx is read before it moves.
    assign n_words = cnt;
    always @(posedge clk) begin
        if (tx.valid === 1'b1) cnt <= cnt + 1;
    end
endmodule
`default_nettype wire

// ---- verif/pvsf_framer_tb.sv ----
// Self-checking bench of the pixel-to-link framer.
`timescale 1ns/1ps
`default_nettype none
module pvsf_framer_tb;
    import pvsf_pkg::*;
    localparam int PU = 20;
    localparam int HD = 4;
    logic        clk = 0, rst = 1, mode = 0, rev, rdy, orv;
    logic [3:0]  st;
    pvsf_pix_t   pixel = '0;
    pvsf_cmd_t   cmd = '0;
    pvsf_route_t route;
    pvsf_tx_t    tx;
    int          mismatches = 0, n_tests = 0, n, w, words;
    logic [7:0]  ra [6] = '{8'h00, 8'h01, 8'h07, 8'h15, 8'h16, 8'h1e};
    logic [7:0]  rv [6] = '{8'h80, 8'h90, 8'h00, 8'h00, 8'h00, 8'h5a};
    // 40 MHz lies inside the single-input pixel clock range.
    always #12.5 clk = ~clk;
    pvsf_framer #(.PWRUP_CYC(PU), .REVHOLD_CYC(HD)) dut_u (
        .clk(clk), .rst(rst), .pixel(pixel), .fcc_in(1'b1),
        .control_mode_select(mode), .cable_type_pin(1'b0),
        .host_iface_pin(1'b0), .rev_ctrl_in(rev), .cmd(cmd),
        .route(route), .tx(tx), .rev_ctrl_out(orv),
        .rev_chan_ready(rdy), .bypass_active(st[3]),
        .local_ctrl_chan_enable(st[2]), .serial_output_enable(st[1]),
        .pixel_clock_detected(st[0]));
    pvsf_far_end far_u (.clk(clk), .tx(tx), .rev_line(rev), .n_words(words));
    // Compare and count.
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // One packet; its answer is looked at in the cycle after it is taken.
    task automatic acc(input logic wr, input logic [7:0] dv, a, d);
        @(posedge clk);
        cmd <= '{1'b1, wr, dv, a, d, 16'h0123};
        @(posedge clk);
        cmd.valid <= 1'b0;
        #1;
    endtask
    // Bounded wait for the reverse-ready level; n ends as the cycle count.
    task automatic till(input int lim);
        n = 0;
        while (rdy !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
            if (n > lim) begin
                chk("wait", 0, 1);
                summarize();
            end
        end
    endtask
    // One pixel sample; n ends as the cycles until a link word, 4 if none.
    task automatic pix(input logic [21:0] d);
        @(posedge clk);
        pixel <= '{1'b1, 1'b0, 1'b0, d};
        @(posedge clk);
        pixel.valid <= 1'b0;
        for (n = 1; n < 4; n++) begin
            #1;
            if (tx.valid === 1'b1) break;
            @(posedge clk);
        end
    endtask
    // Main sequence.
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("rev_gate", 2'b01, {rdy, orv});
        till(PU + 4);
        chk("pwrup", 1, n >= PU && n <= PU + 2);
        repeat (4) @(posedge clk);
        #1;
        chk("rev_pass", 0, orv);
        foreach (ra[i]) begin
            acc(1'b0, 8'h80, ra[i], 8'h00);
            chk("reg", {1'b1, rv[i]},
                {route.rsp_valid, route.rsp_rdata});
        end
        acc(1'b0, 8'h90, 8'h00, 8'h00);
        chk("fwd", 3'b010,
            {route.rsp_valid, route.remote_fwd, route.i2c_req});
        acc(1'b0, 8'h44, 8'h00, 8'h00);
        chk("i2c", 17'h10123, {route.i2c_req, route.bit_period});
        $display("test registers and routing done");
        acc(1'b1, 8'h80, 8'h15, 8'h02);
        chk("mute", 0, rdy);
        chk("outen", 4'h2, st);
        till(HD + 4);
        chk("hold", 1, n >= HD && n <= HD + 2);
        pix(22'h2a5a5a);
        chk("single", 6'h2b, {n[1:0], tx.valid, tx.count});
        // First word after enable: seed key, negative disparity, 3 symbols.
        chk("symbols", 32'h2ada6a9a, tx.symbols[31:0]);
        // 40 MHz suits 11-bit halves, and the low-rate select stays off.
        acc(1'b1, 8'h80, 8'h07, 8'h80);
        w = words;
        pix(22'h0007ff);
        pix(22'h000400);
        chk("pair", 2, n);
        @(posedge clk);
        #1;
        chk("double", w + 1, words);
        acc(1'b1, 8'h80, 8'h07, 8'h00);
        acc(1'b1, 8'h80, 8'h15, 8'h00);
        w = words;
        pix(22'h155555);
        chk("drop", w, words);
        $display("test pixel path done");
        pixel.valid <= 1'b1;
        repeat (10) @(posedge clk);
        pixel.valid <= 1'b0;
        acc(1'b0, 8'h80, 8'h15, 8'h00);
        chk("det_on", 8'h01, route.rsp_rdata);
        chk("det_pin", 4'h1, st);
        repeat (10) @(posedge clk);
        acc(1'b0, 8'h80, 8'h15, 8'h00);
        chk("det_off", 8'h00, route.rsp_rdata);
        acc(1'b1, 8'h80, 8'h00, 8'h82);
        acc(1'b0, 8'h82, 8'h00, 8'h00);
        chk("own", 9'h182, {route.rsp_valid, route.rsp_rdata});
        @(posedge clk);
        mode <= 1'b1;
        repeat (3) @(posedge clk);
        acc(1'b0, 8'h82, 8'h00, 8'h00);
        chk("bypass", 0, route.rsp_valid);
        chk("bypass_pin", 4'h8, st);
        $display("test detect, address and mode done");
        summarize();
    end
endmodule
`default_nettype wire
